// >>> core/cbte_pkg.sv
/*
  Shared constants for the bit-operation and transfer execution unit:
  register map, command word fields, opcodes, flag positions, cycle counts.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package cbte_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_PC = 8'h08;
    localparam logic [7:0] A_SP = 8'h0c;
    localparam logic [7:0] A_PX = 8'h10;
    localparam logic [7:0] A_PY = 8'h14;
    localparam logic [7:0] A_PZ = 8'h18;
    localparam logic [7:0] A_MADR = 8'h1c;
    localparam logic [7:0] A_MDAT = 8'h20;
    // Working registers r0..r15 sit at 0x40..0x7c
    localparam logic [1:0] GPR_PAGE = 2'h1;
    // Command word fields
    localparam int OP_LSB = 24;
    localparam int RD_LSB = 20;
    localparam int B_LSB = 16;
    localparam int PS_LSB = 16;
    // Status flag positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;
    localparam logic [7:0] STATUS_FLAG_REG_RST = 8'h00;
    // I/O region at the bottom of data space
    localparam int IO_BIT_AW = 5;
    localparam int IO_AW = 6;
    localparam logic [15:0] IO_SPAN = 16'h0040;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;
    localparam logic [1:0] CYC_3 = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_BRANCH_IF_IRQ_ON = 5'h01,
        OP_BRANCH_IF_IRQ_OFF = 5'h02, OP_SHIFT_LEFT_LOGICAL = 5'h03,
        OP_SHIFT_RIGHT_LOGICAL = 5'h04, OP_ROTATE_LEFT_CARRY = 5'h05,
        OP_ROTATE_RIGHT_CARRY = 5'h06, OP_SHIFT_RIGHT_SIGNED = 5'h07,
        OP_SWAP = 5'h08, OP_FSET = 5'h09, OP_FCLR = 5'h0a,
        OP_IO_BIT_SET = 5'h0b, OP_IO_BIT_CLEAR = 5'h0c,
        OP_BIT_TO_TFLAG = 5'h0d, OP_TFLAG_TO_BIT = 5'h0e, OP_LD = 5'h0f,
        OP_LDI = 5'h10, OP_LDD = 5'h11, OP_ST = 5'h12, OP_STI = 5'h13,
        OP_STD = 5'h14, OP_DIRECT_LOAD = 5'h15, OP_DIRECT_STORE = 5'h16,
        OP_IN = 5'h17, OP_OUT = 5'h18, OP_PUSH = 5'h19, OP_POP = 5'h1a
    } cbte_op_e;
endpackage : cbte_pkg

// >>> core/cbte_core.sv
/*
  Execution unit for shifts, rotates, bit and flag operations, indirect,
  direct and I/O transfers and stack push/pop of an 8-bit core, with its
  working registers, pointers, stack pointer and data space in flops.
  Assumes an AXI4-Lite master issuing commands and one synchronous clock.
*/
`timescale 1ns/100ps
module cbte_core
    import cbte_pkg::*;
#(
    parameter int DM_AW = 8,
    parameter logic [15:0] SP_RST = 16'h00ff
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    localparam int DM_N = 1 << DM_AW;

    logic [7:0] gpr_r [16];
    logic [7:0] mem_r [DM_N];
    logic [15:0] ptr_r [3];
    logic [15:0] pc_r, sp_r, madr_r;
    logic [7:0] status_flag_reg_r;
    logic [31:0] cmd_r;
    logic go_r;
    logic [1:0] cnt_r, last_cyc_r;
    logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    cbte_op_e c_op;
    logic [3:0] c_rd;
    logic [2:0] c_b;
    logic [1:0] c_ps;
    logic [15:0] c_k;
    logic busy;

    assign c_op = cbte_op_e'(cmd_r[OP_LSB +: 5]);
    assign c_rd = cmd_r[RD_LSB +: 4];
    assign c_b = cmd_r[B_LSB +: 3];
    // Pointer code 3 falls back to Z so no index runs off the array
    assign c_ps = (cmd_r[PS_LSB +: 2] == 2'h3) ? 2'h2 : cmd_r[PS_LSB +: 2];
    assign c_k = cmd_r[15:0];
    assign busy = go_r || (cnt_r != 2'h0);

    // Address of the data-space access of the current command
    logic [15:0] ptr, m_a;
    logic [7:0] m_rd;
    logic io_a;
    always_comb begin
        ptr = ptr_r[c_ps];
        case (c_op)
            OP_LDD, OP_STD: m_a = ptr - ONE16;
            OP_DIRECT_LOAD, OP_DIRECT_STORE: m_a = c_k;
            OP_IN, OP_OUT: m_a = 16'(c_k[IO_AW-1:0]);
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: m_a = 16'(c_k[IO_BIT_AW-1:0]);
            OP_PUSH: m_a = sp_r;
            OP_POP: m_a = sp_r + ONE16;
            default: m_a = ptr;
        endcase
    end
    assign m_rd = mem_r[m_a[DM_AW-1:0]];
    assign io_a = m_a < IO_SPAN;

    // Results of the current command
    logic [7:0] rd_v, res, nf, m_wd;
    logic reg_we, m_we, shf;
    logic [15:0] p_nxt, sp_n, pc_n;
    logic [1:0] cyc;
    always_comb begin
        rd_v = gpr_r[c_rd];
        res = rd_v;
        nf = status_flag_reg_r;
        reg_we = 1'b0;
        shf = 1'b0;
        m_we = 1'b0;
        m_wd = rd_v;
        p_nxt = ptr;
        sp_n = sp_r;
        pc_n = pc_r + ONE16;
        cyc = CYC_1;
        case (c_op)
            OP_BRANCH_IF_IRQ_ON, OP_BRANCH_IF_IRQ_OFF: begin
                if (status_flag_reg_r[F_I] ==
                        (c_op == OP_BRANCH_IF_IRQ_ON)) begin
                    pc_n = pc_r + c_k + ONE16;
                    cyc = CYC_2;
                end
            end
            OP_SHIFT_LEFT_LOGICAL: begin
                res = {rd_v[6:0], 1'b0};
                nf[F_C] = rd_v[7];
                nf[F_H] = rd_v[3];
                shf = 1'b1;
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, rd_v[7:1]};
                nf[F_C] = rd_v[0];
                shf = 1'b1;
            end
            OP_SHIFT_RIGHT_SIGNED: begin
                res = {rd_v[7], rd_v[7:1]};
                nf[F_C] = rd_v[0];
                shf = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY: begin
                res = {rd_v[6:0], status_flag_reg_r[F_C]};
                nf[F_C] = rd_v[7];
                nf[F_H] = rd_v[3];
                shf = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                res = {status_flag_reg_r[F_C], rd_v[7:1]};
                nf[F_C] = rd_v[0];
                shf = 1'b1;
            end
            OP_SWAP: begin
                res = {rd_v[3:0], rd_v[7:4]};
                reg_we = 1'b1;
            end
            OP_FSET: nf[c_b] = 1'b1;
            OP_FCLR: nf[c_b] = 1'b0;
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                m_wd = m_rd;
                m_wd[c_b] = (c_op == OP_IO_BIT_SET);
                m_we = 1'b1;
            end
            OP_BIT_TO_TFLAG: nf[F_T] = rd_v[c_b];
            OP_TFLAG_TO_BIT: begin
                res[c_b] = status_flag_reg_r[F_T];
                reg_we = 1'b1;
            end
            OP_LD: begin
                // I/O reads finish a cycle sooner than SRAM reads
                res = m_rd;
                reg_we = 1'b1;
                cyc = io_a ? CYC_1 : CYC_2;
            end
            OP_LDI: begin
                res = m_rd;
                reg_we = 1'b1;
                p_nxt = ptr + ONE16;
                cyc = CYC_2;
            end
            OP_LDD: begin
                res = m_rd;
                reg_we = 1'b1;
                p_nxt = m_a;
                cyc = io_a ? CYC_2 : CYC_3;
            end
            OP_ST, OP_DIRECT_STORE, OP_OUT: m_we = 1'b1;
            OP_STI: begin
                m_we = 1'b1;
                p_nxt = ptr + ONE16;
            end
            OP_STD: begin
                m_we = 1'b1;
                p_nxt = m_a;
                cyc = CYC_2;
            end
            OP_DIRECT_LOAD, OP_IN: begin
                res = m_rd;
                reg_we = 1'b1;
            end
            OP_PUSH: begin
                m_we = 1'b1;
                sp_n = sp_r - ONE16;
                cyc = CYC_2;
            end
            OP_POP: begin
                res = m_rd;
                reg_we = 1'b1;
                sp_n = m_a;
                cyc = CYC_2;
            end
            default: ;
        endcase
        if (shf) begin
            reg_we = 1'b1;
            nf[F_Z] = (res == 8'h00);
            nf[F_N] = res[7];
            nf[F_V] = res[7] ^ nf[F_C];
        end
    end

    // Bus write decode
    logic wr_go, wr_ok, wr_gpr;
    logic [31:0] wd;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wd[8*i +: 8] = w_strb_r[i] ? w_data_r[8*i +: 8] : 8'h00;
        end
    end
    assign wr_go = aw_have_r && w_have_r && !bvalid_r;
    assign wr_gpr = aw_addr_r[7:6] == GPR_PAGE;
    always_comb begin
        case (aw_addr_r)
            A_CMD: wr_ok = !busy;
            A_STAT, A_PC, A_SP, A_PX, A_PY, A_PZ, A_MADR, A_MDAT: wr_ok = 1'b1;
            default: wr_ok = wr_gpr;
        endcase
    end

    assign awready = !aw_have_r && !bvalid_r;
    assign wready = !w_have_r && !bvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Command launch and cycle accounting
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_r <= 32'h0;
            go_r <= 1'b0;
            cnt_r <= 2'h0;
            last_cyc_r <= 2'h0;
        end else begin
            go_r <= wr_go && wr_ok && aw_addr_r == A_CMD;
            if (wr_go && wr_ok && aw_addr_r == A_CMD) begin
                cmd_r <= wd;
            end
            if (go_r) begin
                cnt_r <= cyc - CYC_1;
                last_cyc_r <= cyc;
            end else if (cnt_r != 2'h0) begin
                cnt_r <= cnt_r - CYC_1;
            end
        end
    end

    // Architectural state; a command and a bus write never meet here
    always_ff @(posedge clock) begin
        if (rst) begin
            status_flag_reg_r <= STATUS_FLAG_REG_RST;
            pc_r <= 16'h0;
            sp_r <= SP_RST;
            madr_r <= 16'h0;
            for (int i = 0; i < 3; i++) begin
                ptr_r[i] <= 16'h0;
            end
        end else if (go_r) begin
            status_flag_reg_r <= nf;
            pc_r <= pc_n;
            sp_r <= sp_n;
            ptr_r[c_ps] <= p_nxt;
        end else if (wr_go && wr_ok) begin
            case (aw_addr_r)
                A_STAT: status_flag_reg_r <= wd[7:0];
                A_PC: pc_r <= wd[15:0];
                A_SP: sp_r <= wd[15:0];
                A_PX: ptr_r[0] <= wd[15:0];
                A_PY: ptr_r[1] <= wd[15:0];
                A_PZ: ptr_r[2] <= wd[15:0];
                A_MADR: madr_r <= wd[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                gpr_r[i] <= 8'h00;
            end
        end else if (go_r && reg_we) begin
            gpr_r[c_rd] <= res;
        end else if (wr_go && wr_gpr) begin
            gpr_r[aw_addr_r[5:2]] <= wd[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DM_N; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (go_r && m_we) begin
            mem_r[m_a[DM_AW-1:0]] <= m_wd;
        end else if (wr_go && aw_addr_r == A_MDAT) begin
            mem_r[madr_r[DM_AW-1:0]] <= wd[7:0];
        end
    end

    // Bus read
    logic [31:0] rmux;
    logic rok;
    always_comb begin
        rok = 1'b1;
        rmux = 32'h0;
        if (araddr[7:6] == GPR_PAGE) begin
            rmux = {24'h0, gpr_r[araddr[5:2]]};
        end else begin
            case (araddr)
                A_CMD: rmux = cmd_r;
                A_STAT: rmux = {21'h0, last_cyc_r, busy, status_flag_reg_r};
                A_PC: rmux = {16'h0, pc_r};
                A_SP: rmux = {16'h0, sp_r};
                A_PX: rmux = {16'h0, ptr_r[0]};
                A_PY: rmux = {16'h0, ptr_r[1]};
                A_PZ: rmux = {16'h0, ptr_r[2]};
                A_MADR: rmux = {16'h0, madr_r};
                A_MDAT: rmux = {24'h0, mem_r[madr_r[DM_AW-1:0]]};
                default: rok = 1'b0;
            endcase
        end
    end

    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rmux;
            rresp_r <= rok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : cbte_core

// >>> tb/cbte_chk.sv
/*
  Bus protocol checker for the execution unit's AXI4-Lite slave port.
  Assumes one clock and an active-high synchronous reset.
*/
`timescale 1ns/100ps
module cbte_chk
    import cbte_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence aw_t;
        awvalid && awready;
    endsequence
    sequence w_t;
        wvalid && wready;
    endsequence

    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped early");
    ar_ready_a: assert property (arready != rvalid)
        else $error("read address ready wrong");
    b_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    r_lat_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    b_lat_a: assert property ((aw_t and w_t) |-> ##2 bvalid)
        else $error("write answer late");
    b_done_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    r_done_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read response repeated");
    resp_code_a: assert property (rvalid |->
        rresp == RESP_OKAY || rresp == RESP_SLVERR)
        else $error("bad read response code");
endmodule : cbte_chk

bind cbte_core cbte_chk u_chk (.clock(clock), .rst(rst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));

// >>> tb/cbte_axi_mst.sv
/*
  AXI4-Lite master standing in for the host of the execution unit.
  Assumes one clock; the bench calls wr and rd one at a time.
*/
`timescale 1ns/100ps
module cbte_axi_mst (
    input wire logic clock,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
    end

    task wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(ad && wd));
        while (!bvalid) @(posedge clock);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : cbte_axi_mst

// >>> tb/test_cpu_bitops_transfer_exec.sv
/*
  Self-checking bench: runs every command except OP_NOP through the register bus and
  compares with a model kept here. Assumes the core's default parameters.
*/
`timescale 1ns/100ps
module test_cpu_bitops_transfer_exec
    import cbte_pkg::*;
;
    logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, dd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] v, e, f, a;
    logic [15:0] p, k, np;
    logic c, ld, pre;
    int fails, num_checks, cyc, n, ps, b;
    cbte_op_e o;
    cbte_op_e sh[6] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_SIGNED,
        OP_SWAP};
    cbte_op_e xf[10] = '{OP_LD, OP_LDI, OP_LDD, OP_ST, OP_STI, OP_STD,
        OP_DIRECT_LOAD, OP_DIRECT_STORE, OP_IN, OP_OUT};

    cbte_core uut (.clock(clock), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));
    cbte_axi_mst u_m (.clock(clock), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task close_out;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Hang guard: the whole sequence needs well under a tenth of this
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            close_out;
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    function automatic logic [7:0] ra(input int i);
        return 8'(64 + 4 * i);
    endfunction : ra

    task w(input logic [7:0] ad, input logic [31:0] d);
        u_m.wr(ad, d, rs);
    endtask : w

    task r(input logic [7:0] ad);
        u_m.rd(ad, dd, rs);
    endtask : r

    // Leaves the final status word in dd
    task run(input cbte_op_e op, input int d, input int bi, input int kk);
        w(A_CMD, {3'h0, op, 4'(d), 1'b0, 3'(bi), 16'(kk)});
        do r(A_STAT); while (dd[8] !== 1'b0);
    endtask : run

    initial begin
        rst = 1'b1;
        fails = 0;
        num_checks = 0;
        void'($urandom(32'h16897c58));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        r(A_SP);
        chk(dd, 32'h00ff);
        for (int i = 0; i < 24; i++) begin
            o = sh[i % 6];
            v = 8'($urandom);
            f = 8'($urandom);
            w(ra(1), 32'(v));
            w(A_STAT, 32'(f));
            run(o, 1, 0, 0);
            c = v[0];
            case (o)
                OP_SHIFT_LEFT_LOGICAL: e = v << 1;
                OP_SHIFT_RIGHT_LOGICAL: e = v >> 1;
                OP_ROTATE_LEFT_CARRY: e = {v[6:0], f[F_C]};
                OP_ROTATE_RIGHT_CARRY: e = {f[F_C], v[7:1]};
                OP_SHIFT_RIGHT_SIGNED: e = {v[7], v[7:1]};
                default: e = {v[3:0], v[7:4]};
            endcase
            if (o inside {OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY})
                c = v[7];
            if (o != OP_SWAP) begin
                f[F_C] = c;
                f[F_Z] = (e == 8'h00);
                f[F_N] = e[7];
                f[F_V] = e[7] ^ c;
                if (o inside {OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY})
                    f[F_H] = v[3];
            end
            chk(dd[7:0], f);
            chk(dd[10:9], 1);
            r(ra(1));
            chk(dd, 32'(e));
        end
        for (int s = 0; s < 8; s++) begin
            f = 8'($urandom);
            w(A_STAT, 32'(f));
            run(OP_FSET, 0, s, 0);
            f[s] = 1'b1;
            chk(dd[10:0], {3'h2, f});
            run(OP_FCLR, 0, s, 0);
            f[s] = 1'b0;
            chk(dd[10:0], {3'h2, f});
        end
        for (int i = 0; i < 4; i++) begin
            p = 16'($urandom);
            k = 16'($urandom);
            w(A_PC, 32'(p));
            w(A_STAT, {24'h0, i[0], 7'h00});
            run(i[1] ? OP_BRANCH_IF_IRQ_OFF : OP_BRANCH_IF_IRQ_ON, 0, 0, k);
            c = (i[1] != i[0]);
            chk(dd[10:9], c ? 2 : 1);
            r(A_PC);
            chk(dd, 32'(16'(p + (c ? k + 16'h1 : 16'h1))));
        end
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom_range(0, 31));
            b = $urandom_range(0, 7);
            v = 8'($urandom);
            f = 8'($urandom);
            w(A_MADR, 32'(a));
            w(A_MDAT, 32'(v));
            w(A_STAT, 32'(f));
            run(i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 0, b, a);
            chk(dd[10:0], {3'h2, f});
            v[b] = !i[0];
            r(A_MDAT);
            chk(dd, 32'(v));
            w(ra(2), 32'(f));
            w(A_STAT, 32'h0);
            run(OP_BIT_TO_TFLAG, 2, b, 0);
            chk(dd[10:0], {3'h2, 1'b0, f[b], 6'h00});
            w(ra(3), 32'(v));
            run(OP_TFLAG_TO_BIT, 3, 7 - b, 0);
            chk(dd[10:0], {3'h2, 1'b0, f[b], 6'h00});
            v[7 - b] = f[b];
            r(ra(3));
            chk(dd, 32'(v));
        end
        for (int i = 0; i < 30; i++) begin
            o = xf[i % 10];
            ps = i / 10;
            p = 16'(ps == 0 ? $urandom_range(1, 64) : $urandom_range(65, 255));
            pre = o inside {OP_LDD, OP_STD};
            ld = o inside {OP_LD, OP_LDI, OP_LDD, OP_DIRECT_LOAD, OP_IN};
            a = pre ? 8'(p - 16'h1) : p[7:0];
            if (o inside {OP_IN, OP_OUT})
                a = a & 8'h3f;
            np = o inside {OP_LDI, OP_STI} ? p + 16'h1 : pre ? p - 16'h1 : p;
            n = o == OP_LD ? (a < 64 ? 1 : 2) : o == OP_LDD ? (a < 64 ? 2 : 3)
                : o inside {OP_LDI, OP_STD} ? 2 : 1;
            v = 8'($urandom);
            f = 8'($urandom);
            w(A_PX + 8'(4 * ps), 32'(p));
            w(A_STAT, 32'(f));
            if (ld) begin
                w(A_MADR, 32'(a));
                w(A_MDAT, 32'(v));
            end else
                w(ra(6), 32'(v));
            run(o, 6, ps, a);
            chk(dd[7:0], f);
            chk(dd[10:9], n);
            r(A_PX + 8'(4 * ps));
            chk(dd, 32'(np));
            if (ld)
                r(ra(6));
            else begin
                w(A_MADR, 32'(a));
                r(A_MDAT);
            end
            chk(dd, 32'(v));
        end
        for (int i = 0; i < 2; i++) begin
            p = 16'($urandom_range(65, 254));
            v = 8'($urandom);
            w(A_SP, 32'(p));
            w(ra(4), 32'(v));
            run(OP_PUSH, 4, 0, 0);
            chk(dd[10:9], 2);
            r(A_SP);
            chk(dd, 32'(p - 16'h1));
            w(A_MADR, 32'(p));
            r(A_MDAT);
            chk(dd, 32'(v));
            run(OP_POP, 5, 0, 0);
            chk(dd[10:9], 2);
            r(A_SP);
            chk(dd, 32'(p));
            r(ra(5));
            chk(dd, 32'(v));
        end
        // Unmapped offset must be refused both ways
        u_m.wr(8'h24, 32'h5a, rs);
        chk(rs, RESP_SLVERR);
        u_m.rd(8'h24, dd, rs);
        chk({dd[29:0], rs}, {30'h0, RESP_SLVERR});
        close_out;
    end
endmodule : test_cpu_bitops_transfer_exec
